/* File: rtl/pdd_decoder.sv */
// pdd_decoder: digital phase angle decoder, remap pwm, dynamic filter and dim output
// assumes analog comparators outside; asynchronous pins pass two flip-flops
//
// Behaviour
// - the line sense comparator bit (line above 356 mV) gives a twice line frequency pulse whose duty is the angle.
// - the sampled angle is remapped logarithmically into a 300 Hz pwm for finer low level resolution.
// - the remapped duty is clamped to a minimum so contrast stays near 70:1.
// - the remapped pwm drives the decoded pwm node buffer, whose high level is the range adjust voltage.
// - the filtered level node code is compared with a 500 Hz triangle and the inverted result drives dim.
// - the dim output is open drain, only sinking and never driving high.
// - the sample interval varies with previous decoded angles and the present measurement.
// - with no dimmer movement the 500k series resistor is inserted, selecting the slow filter.
// - a large change in decoded angle bypasses the series resistor, selecting the fast filter.
// - an angle above 85% keeps the fast filter except in shutdown, so range adjust alone scales dim.
// - a range adjust level below 75 mV enters low power shutdown.
// - full light is reached at angles of 70% at 3 V, 80% at 2.5 V and 95% at 2 V adjust.
// - a falling supply undervoltage trip turns on pull downs on both filter nodes.
// - above 160 C the switch drive is disabled until the die cools by 20 C.
// - in low power shutdown the dim output stays high, meaning zero light.
`timescale 1ns/1ps
module pdd_decoder
  import pdd_pkg::*;
#(
  parameter int unsigned PWM_PERIOD = PWM1_CYC,
  parameter int unsigned TRI_PERIOD = TRI_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic line_above_thr,
  input wire logic [pdd_pkg::LVL_W-1:0] range_adjust_code,
  input wire logic [pdd_pkg::LVL_W-1:0] filtered_level_code,
  input wire logic uvlo_fall,
  input wire logic temp_over_160,
  input wire logic temp_below_140,
  input wire logic gate_req,
  output logic decoded_pwm_on,
  output logic [pdd_pkg::LVL_W-1:0] decoded_pwm_level,
  output logic series_bypass,
  output logic decoded_pwm_node_pd,
  output logic filtered_level_node_pd,
  output logic dim_o,
  output logic dim_oe_n,
  output logic shutdown,
  output logic gate_drive,
  output logic [pdd_pkg::ANG_W-1:0] angle
);
  import pdd_pkg::*;

  // elaboration check on period parameters
  if (PWM_PERIOD < 256 || PWM_PERIOD >= (1 << 24) || TRI_PERIOD < 512 || TRI_PERIOD >= (1 << 24)) begin : g_bad_period
    $error("pdd_decoder: period parameters out of range");
  end

  // exponent from top bits, mantissa below: fine steps at low angles
  function automatic logic [7:0] log_map(input logic [7:0] a);
    logic [12:0] v;
    v = 13'({1'b1, a[4:0]}) << a[7:5];
    return v[12:5];
  endfunction

  function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // synchronisers
  logic [1:0] ln_s_r, uv_s_r, th_s_r, tl_s_r;
  logic line_r, line_pv_r, uv_r, th_r, tl_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ln_s_r <= '0;
      uv_s_r <= '0;
      th_s_r <= '0;
      tl_s_r <= '0;
    end else begin
      ln_s_r <= {ln_s_r[0], line_above_thr};
      uv_s_r <= {uv_s_r[0], uvlo_fall};
      th_s_r <= {th_s_r[0], temp_over_160};
      tl_s_r <= {tl_s_r[0], temp_below_140};
    end
  end
  assign line_r = ln_s_r[1];
  assign uv_r = uv_s_r[1];
  assign th_r = th_s_r[1];
  assign tl_r = tl_s_r[1];

  // angle measurement per half line cycle
  logic [HALF_W-1:0] hi_cnt_r, hi_cnt_nxt, tot_cnt_r, tot_cnt_nxt;
  logic [ANG_W-1:0] angle_r, angle_nxt, prev_ang_r, prev_ang_nxt;
  logic half_done;
  logic [HALF_W+ANG_W-1:0] scaled;
  always_comb begin
    half_done = 1'b0;
    hi_cnt_nxt = hi_cnt_r;
    tot_cnt_nxt = tot_cnt_r;
    angle_nxt = angle_r;
    scaled = '0;
    if (tot_cnt_r != '1) tot_cnt_nxt = tot_cnt_r + 1'b1;
    if (line_r && hi_cnt_r != '1) hi_cnt_nxt = hi_cnt_r + 1'b1;
    half_done = line_r && !line_pv_r;
    if (half_done) begin
      if (tot_cnt_r > HALF_W'(HALF_MIN)) begin
        scaled = ({{ANG_W{1'b0}}, hi_cnt_r} << ANG_W) / {{ANG_W{1'b0}}, tot_cnt_r};
        angle_nxt = (scaled >= ANG_FULL) ? '1 : scaled[ANG_W-1:0];
      end
      hi_cnt_nxt = HALF_W'(1);
      tot_cnt_nxt = HALF_W'(1);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_cnt_r <= '0;
      tot_cnt_r <= '0;
      angle_r <= '0;
      line_pv_r <= 1'b0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      tot_cnt_r <= tot_cnt_nxt;
      angle_r <= angle_nxt;
      line_pv_r <= line_r;
    end
  end
  assign angle = angle_r;

  // variable sampling and filter mode
  pdd_mode_e mode_r, mode_nxt;
  logic [3:0] skip_r, skip_nxt;
  logic [7:0] samp_r, samp_nxt;
  logic adj_off;
  assign adj_off = range_adjust_code < ADJ_OFF;
  always_comb begin
    mode_nxt = mode_r;
    skip_nxt = skip_r;
    samp_nxt = samp_r;
    prev_ang_nxt = prev_ang_r;
    if (half_done) begin
      if (skip_r != '0) skip_nxt = skip_r - 1'b1;
      // interval from past and present angle
      if (skip_r == '0 || absdiff(angle_nxt, prev_ang_r) > BIG_STEP) begin
        prev_ang_nxt = angle_nxt;
        samp_nxt = angle_nxt;
        if (absdiff(angle_nxt, prev_ang_r) > BIG_STEP || absdiff(samp_r, prev_ang_r) > BIG_STEP) begin
          skip_nxt = SAMP_FAST;
          mode_nxt = PDD_MOVING;
        end else begin
          skip_nxt = SAMP_SLOW;
          mode_nxt = PDD_STANDBY;
        end
      end
    end
    if (angle_nxt > FAST_PCT && mode_nxt != PDD_SHUTDN) mode_nxt = PDD_ANALOG;
    else if (mode_r == PDD_ANALOG && angle_nxt <= FAST_PCT) mode_nxt = PDD_MOVING;
    if (adj_off) mode_nxt = PDD_SHUTDN;
    else if (mode_r == PDD_SHUTDN) mode_nxt = PDD_MOVING;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= PDD_STANDBY;
      skip_r <= '0;
      samp_r <= '0;
      prev_ang_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      skip_r <= skip_nxt;
      samp_r <= samp_nxt;
      prev_ang_r <= prev_ang_nxt;
    end
  end

  // 300 hz remap pwm and 500 hz triangle
  logic [23:0] pcnt_r, pcnt_nxt, tcnt_r, tcnt_nxt;
  logic [7:0] duty, tri_v, full_ang;
  logic [31:0] thr;
  always_comb begin
    case (1'b1)
      range_adjust_code >= ADJ_3V0: full_ang = ANG_70;
      range_adjust_code >= ADJ_2V5: full_ang = ANG_80;
      default: full_ang = ANG_95;
    endcase
    duty = log_map(samp_r);
    if (samp_r >= full_ang) duty = 8'hFF;
    if (duty < MIN_DUTY) duty = MIN_DUTY;
    pcnt_nxt = (pcnt_r >= 24'(PWM_PERIOD - 1)) ? '0 : pcnt_r + 1'b1;
    tcnt_nxt = (tcnt_r >= 24'(TRI_PERIOD - 1)) ? '0 : tcnt_r + 1'b1;
    // full scale duty gives a full period high
    thr = (32'(duty) * 32'(PWM_PERIOD)) / 32'(8'hFF);
    // peak stays at 255, no wrap to zero
    if (tcnt_r < 24'(TRI_PERIOD / 2)) tri_v = 8'((32'(tcnt_r) * 510) / TRI_PERIOD);
    else tri_v = 8'((32'(TRI_PERIOD - 32'(tcnt_r)) * 510) / TRI_PERIOD);
  end

  // outputs
  logic pwm_on_nxt, dim_low_nxt, gate_off_r, gate_off_nxt;
  logic pwm_on_r, dim_low_r;
  always_comb begin
    pwm_on_nxt = (32'(pcnt_r) < thr) && (mode_r != PDD_SHUTDN);
    // high filtered level sinks dim low, so dim is the inverted compare
    dim_low_nxt = (filtered_level_code > tri_v) && (mode_r != PDD_SHUTDN);
    gate_off_nxt = gate_off_r;
    if (th_r) gate_off_nxt = 1'b1;
    else if (tl_r) gate_off_nxt = 1'b0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcnt_r <= '0;
      tcnt_r <= '0;
      pwm_on_r <= 1'b0;
      dim_low_r <= 1'b0;
      gate_off_r <= 1'b0;
    end else begin
      pcnt_r <= pcnt_nxt;
      tcnt_r <= tcnt_nxt;
      pwm_on_r <= pwm_on_nxt;
      dim_low_r <= dim_low_nxt;
      gate_off_r <= gate_off_nxt;
    end
  end

  assign decoded_pwm_on = pwm_on_r;
  assign decoded_pwm_level = (mode_r == PDD_SHUTDN) ? '0 : range_adjust_code;
  assign series_bypass = (mode_r == PDD_MOVING) || (mode_r == PDD_ANALOG);
  assign decoded_pwm_node_pd = uv_r;
  assign filtered_level_node_pd = uv_r;
  assign dim_o = 1'b0;
  assign dim_oe_n = !(dim_low_r && !uv_r);
  assign shutdown = (mode_r == PDD_SHUTDN);
  assign gate_drive = gate_req && !gate_off_r;
endmodule // pdd_decoder

/* File: rtl/pdd_pkg.sv */
// pdd_pkg: constants and types for the phase angle dimming decoder
// assumes a 40 MHz clock; analog levels arrive as comparator bits or adc codes
package pdd_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PWM1_HZ = 300;
  localparam int unsigned TRI_HZ = 500;
  localparam int unsigned PWM1_CYC = CLK_HZ / PWM1_HZ;
  localparam int unsigned TRI_CYC = CLK_HZ / TRI_HZ;
  localparam int unsigned LVL_W = 8;
  localparam int unsigned ANG_W = 8;
  localparam int unsigned HALF_W = 20;
  localparam int unsigned ANG_FULL = 256;
  localparam int unsigned MIN_DUTY_DIV = 70;
  localparam logic [7:0] MIN_DUTY = 8'h04;
  localparam logic [7:0] FAST_PCT = 8'hD9;
  localparam logic [7:0] BIG_STEP = 8'h10;
  localparam logic [7:0] ADJ_OFF = 8'h06;
  localparam logic [7:0] ADJ_3V0 = 8'hF5;
  localparam logic [7:0] ADJ_2V5 = 8'hCC;
  localparam logic [7:0] ANG_70 = 8'hB3;
  localparam logic [7:0] ANG_80 = 8'hCC;
  localparam logic [7:0] ANG_95 = 8'hF3;
  localparam logic [3:0] SAMP_FAST = 4'h1;
  localparam logic [3:0] SAMP_SLOW = 4'h8;
  localparam logic [7:0] HALF_MIN = 8'h10;
  typedef enum logic [1:0] {
    PDD_STANDBY = 2'b00,
    PDD_MOVING = 2'b01,
    PDD_ANALOG = 2'b11,
    PDD_SHUTDN = 2'b10
  } pdd_mode_e;
endpackage

/* File: verif/pdd_decoder_asserts.sv */
// pdd_decoder_asserts: port checks for the decoder
// assumes bind onto pdd_decoder, one clock domain
`timescale 1ns/1ps
module pdd_decoder_asserts
  import pdd_pkg::*;
#(
  parameter int unsigned PWM_PERIOD = 1024,
  parameter int unsigned TRI_PERIOD = 1024
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [pdd_pkg::LVL_W-1:0] range_adjust_code,
  input wire logic uvlo_fall,
  input wire logic temp_over_160,
  input wire logic temp_below_140,
  input wire logic gate_req,
  input wire logic [pdd_pkg::LVL_W-1:0] decoded_pwm_level,
  input wire logic series_bypass,
  input wire logic decoded_pwm_node_pd,
  input wire logic filtered_level_node_pd,
  input wire logic dim_o,
  input wire logic dim_oe_n,
  input wire logic shutdown,
  input wire logic gate_drive,
  input wire logic [pdd_pkg::ANG_W-1:0] angle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_hot; (temp_over_160 && !temp_below_140) [*4]; endsequence
  sequence s_cool; (temp_below_140 && !temp_over_160) [*4]; endsequence
  sequence s_adj_off; (range_adjust_code < ADJ_OFF) [*3]; endsequence
  AST_DIM_OD: assert property (dim_o == 1'b0) else $error("dim driven high");
  AST_PD_PAIR: assert property (decoded_pwm_node_pd == filtered_level_node_pd) else $error("pd split");
  AST_PD_ON: assert property (uvlo_fall [*3] |-> decoded_pwm_node_pd) else $error("pd late");
  AST_PD_OFF: assert property (!uvlo_fall [*3] |-> !filtered_level_node_pd) else $error("pd stuck");
  AST_SHUT_IN: assert property (s_adj_off |-> shutdown) else $error("no shutdown");
  AST_SHUT_DIM: assert property (shutdown [*2] |-> dim_oe_n) else $error("light in shutdown");
  AST_SHUT_LVL: assert property (shutdown && range_adjust_code < ADJ_OFF |-> decoded_pwm_level == 8'h00)
    else $error("level in shutdown");
  AST_LVL: assert property (!shutdown && range_adjust_code >= ADJ_OFF |-> decoded_pwm_level == range_adjust_code)
    else $error("level not adjust");
  AST_HOT: assert property (s_hot |-> !gate_drive) else $error("gate on when hot");
  AST_COOL: assert property (s_cool |-> gate_drive == gate_req) else $error("gate off when cool");
  AST_FAST: assert property (!$stable(angle) && angle > FAST_PCT && !shutdown |-> series_bypass)
    else $error("slow filter at high angle");
endmodule // pdd_decoder_asserts
bind pdd_decoder pdd_decoder_asserts #(.PWM_PERIOD(PWM_PERIOD), .TRI_PERIOD(TRI_PERIOD)) pdd_decoder_asserts_i (.*);

/* File: verif/pdd_opto_rx.sv */
// pdd_opto_rx: opto led seen from the dim pin
// assumes pull-up to supply, pin sinks only
`timescale 1ns/1ps
module pdd_opto_rx (
  input wire logic dim_o,
  input wire logic dim_oe_n,
  output logic light_on
);
  assign light_on = dim_oe_n ? 1'b0 : ~dim_o;
endmodule // pdd_opto_rx

/* File: verif/pdd_decoder_tb_top.sv */
// pdd_decoder_tb_top: scenario bench for the decoder
// assumes short pwm and triangle periods of 1024
`timescale 1ns/1ps
module pdd_decoder_tb_top;
  import pdd_pkg::*;
  logic clk = 0, rst = 1, line_above_thr = 0, uvlo_fall = 0;
  logic temp_over_160 = 0, temp_below_140 = 1, gate_req = 0;
  logic [7:0] range_adjust_code = ADJ_3V0, filtered_level_code = 8'h00;
  logic decoded_pwm_on, series_bypass, decoded_pwm_node_pd, filtered_level_node_pd;
  logic dim_o, dim_oe_n, shutdown, gate_drive, light_on, byp_seen;
  logic [7:0] decoded_pwm_level, angle;
  int error_cnt = 0, total_checks = 0, hi_cnt, sunk_cnt;
  always #12.5 clk = ~clk;
  pdd_decoder #(.PWM_PERIOD(1024), .TRI_PERIOD(1024)) pdd_decoder_i (.clk, .rst, .line_above_thr,
    .range_adjust_code, .filtered_level_code, .uvlo_fall, .temp_over_160, .temp_below_140, .gate_req,
    .decoded_pwm_on, .decoded_pwm_level, .series_bypass, .decoded_pwm_node_pd, .filtered_level_node_pd,
    .dim_o, .dim_oe_n, .shutdown, .gate_drive, .angle);
  pdd_opto_rx pdd_opto_rx_i (.dim_o, .dim_oe_n, .light_on);
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
      hi_cnt += (decoded_pwm_on === 1'b1);
      sunk_cnt += (light_on === 1'b1);
      byp_seen |= series_bypass;
    end
  endtask
  task half(input int h, input int n);
    repeat (n) begin
      line_above_thr = 1;
      tick(h);
      line_above_thr = 0;
      tick(256 - h);
    end
  endtask
  task t_angle;
    half(64, 12);
    check(angle, 8'h40);
    check(series_bypass, 1'b0);
    byp_seen = 0;
    half(160, 10);
    check(byp_seen, 1'b1);
    check(angle, 8'hA0);
    byp_seen = 0;
    half(168, 10);
    check(byp_seen, 1'b0);
    check(angle, 8'hA8);
  endtask
  task t_full;
    half(230, 10);
    check(series_bypass, 1'b1);
    hi_cnt = 0;
    half(230, 8);
    check(hi_cnt == 2048, 1'b1);
    range_adjust_code = 8'hA0;
    hi_cnt = 0;
    half(230, 8);
    check(hi_cnt < 2048, 1'b1);
    range_adjust_code = ADJ_2V5;
    tick(4);
    hi_cnt = 0;
    half(230, 8);
    check(hi_cnt == 2048, 1'b1);
    range_adjust_code = ADJ_3V0;
    half(8, 12);
    hi_cnt = 0;
    half(8, 8);
    check(hi_cnt != 0, 1'b1);
    check(hi_cnt < 1024, 1'b1);
  endtask
  task t_dim;
    tick(4);
    sunk_cnt = 0;
    tick(1024);
    check(sunk_cnt == 0, 1'b1);
    filtered_level_code = 8'hFF;
    tick(4);
    sunk_cnt = 0;
    tick(1024);
    check(sunk_cnt > 900, 1'b1);
    range_adjust_code = 8'h03;
    tick(8);
    check(shutdown, 1'b1);
    check(decoded_pwm_level, 8'h00);
    check(light_on, 1'b0);
    range_adjust_code = ADJ_3V0;
    tick(4);
    check(shutdown, 1'b0);
  endtask
  task t_prot;
    uvlo_fall = 1;
    tick(4);
    check({decoded_pwm_node_pd, filtered_level_node_pd}, 8'h03);
    uvlo_fall = 0;
    gate_req = 1;
    temp_below_140 = 0;
    temp_over_160 = 1;
    tick(5);
    check(gate_drive, 1'b0);
    temp_over_160 = 0;
    tick(5);
    check(gate_drive, 1'b0);
    temp_below_140 = 1;
    tick(5);
    check(gate_drive, 1'b1);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    #2 rst = 0;
    t_angle;
    t_full;
    t_dim;
    t_prot;
    stop_test;
  end
endmodule // pdd_decoder_tb_top
